// *** gpfp_port.sv ***
// Eight-pin port: APB register slave, pad drive and pull control, input sampling and events.
// Assumes pad_in is already synchronous to pclk and the pad cells act on pad_ctrl.
`timescale 1ns/10ps

module gpfp_port
    import gpfp_pkg::*;
(
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Pads
    input  wire logic [PIN_COUNT-1:0]  pad_in,
    output gpfp_pad_ctrl_s             pad_ctrl,
    // Port request toward the interrupt controller
    output logic                       port_irq
);

    // ==========================================================
    // Address decode
    // Both views decode to the same storage, so fast and regular accesses cannot diverge.
    function automatic gpfp_reg_sel_e decode_sel(input logic [ADDR_W-1:0] addr);
        logic [9:0] idx;
        idx = addr[ADDR_W-1:2];
        decode_sel = SEL_NONE;
        if (addr[1:0] != 2'b00) begin
            decode_sel = SEL_NONE;
        end else if (idx == IDX_FAST_DRIVE_SELECT || idx == IDX_REG_DRIVE_SELECT) begin
            decode_sel = SEL_DRIVE_SELECT;
        end else if (idx == IDX_FAST_DRIVE_LEVEL || idx == IDX_REG_DRIVE_LEVEL) begin
            decode_sel = SEL_DRIVE_LEVEL;
        end else if (idx == IDX_FAST_SAMPLED_LEVELS || idx == IDX_REG_SAMPLED_LEVELS) begin
            decode_sel = SEL_SAMPLED_LEVELS;
        end else if (idx == IDX_FAST_EVENT_FLAGS || idx == IDX_REG_EVENT_FLAGS) begin
            decode_sel = SEL_EVENT_FLAGS;
        end else if (idx == IDX_PORT_SLEW_CONTROL) begin
            decode_sel = SEL_SLEW_CONTROL;
        end else if (idx >= IDX_PAD_CONFIG_BASE && idx < IDX_PAD_CONFIG_BASE + 10'd8) begin
            decode_sel = SEL_PAD_CONFIG;
        end
    endfunction

    // Reserved codes 0x6 and 0x7 behave like code 0x0.
    function automatic logic buffer_on(input logic [2:0] sense);
        buffer_on = (sense != SENSE_BUFFER_OFF);
    endfunction

    // ==========================================================
    // Storage
    logic [7:0]         drive_select_r;
    logic [7:0]         drive_select_nxt;
    logic [7:0]         drive_level_r;
    logic [7:0]         drive_level_nxt;
    logic [7:0]         sampled_r;
    logic [7:0]         sampled_nxt;
    logic [7:0]         event_flags_r;
    logic [7:0]         event_flags_nxt;
    logic [7:0]         slew_control_r;
    logic [7:0]         slew_control_nxt;
    gpfp_pad_config_s   pad_config_r   [PIN_COUNT];
    gpfp_pad_config_s   pad_config_nxt [PIN_COUNT];
    logic [31:0]        prdata_r;
    logic [31:0]        prdata_nxt;
    gpfp_pad_ctrl_s     pad_ctrl_r;
    gpfp_pad_ctrl_s     pad_ctrl_nxt;
    logic               irq_r;
    logic               irq_nxt;

    gpfp_reg_sel_e      sel;
    logic [2:0]         pin_idx;
    logic               wr_en;
    logic               rd_setup;
    logic [7:0]         wbyte;
    logic [7:0]         pad_now;
    logic [7:0]         buf_on;
    logic [7:0]         inv;
    logic [7:0]         hit;

    assign sel      = decode_sel(paddr);
    assign pin_idx  = paddr[4:2];
    assign wr_en    = psel && penable && pwrite && (sel != SEL_NONE);
    assign rd_setup = psel && !penable && !pwrite;
    assign wbyte    = pwdata[7:0];

    // ==========================================================
    // Per-pin sampling and event detection
    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g++) begin : g_pin
            assign inv[g]     = pad_config_r[g].pad_invert_enable;
            assign buf_on[g]  = buffer_on(pad_config_r[g].sense_select);
            assign pad_now[g] = pad_in[g] ^ inv[g];
            always_comb begin
                unique case (pad_config_r[g].sense_select)
                    SENSE_ANY_TRANSITION: hit[g] = pad_now[g] != sampled_r[g];
                    SENSE_RISING:         hit[g] = pad_now[g] && !sampled_r[g];
                    SENSE_FALLING:        hit[g] = !pad_now[g] && sampled_r[g];
                    SENSE_LOW_LEVEL:      hit[g] = !pad_now[g];
                    default:              hit[g] = 1'b0;
                endcase
            end
        end
    endgenerate

    // ==========================================================
    // Next register values
    always_comb begin
        drive_select_nxt = drive_select_r;
        drive_level_nxt  = drive_level_r;
        slew_control_nxt = slew_control_r;
        for (int i = 0; i < PIN_COUNT; i++) begin
            pad_config_nxt[i] = pad_config_r[i];
        end
        // Disabled buffers keep their last sampled value.
        sampled_nxt = (pad_now & buf_on) | (sampled_r & ~buf_on);
        event_flags_nxt = event_flags_r;
        if (wr_en) begin
            unique case (sel)
                SEL_DRIVE_SELECT:   drive_select_nxt = wbyte;
                SEL_DRIVE_LEVEL:    drive_level_nxt  = wbyte;
                SEL_SAMPLED_LEVELS: drive_level_nxt  = drive_level_r ^ wbyte;
                SEL_EVENT_FLAGS:    event_flags_nxt  = event_flags_r & ~wbyte;
                SEL_SLEW_CONTROL:   slew_control_nxt = wbyte & 8'h01;
                SEL_PAD_CONFIG:     pad_config_nxt[pin_idx] = wbyte & PAD_CONFIG_RW_MASK;
                default:            drive_select_nxt = drive_select_r;
            endcase
        end
        // A new event wins over a clear in the same cycle.
        event_flags_nxt = event_flags_nxt | (hit & buf_on);
        irq_nxt = |event_flags_nxt;
    end

    // Pad controls are computed from next values so they change with the register.
    always_comb begin
        logic [7:0] inv_nxt;
        inv_nxt = 8'h00;
        for (int i = 0; i < PIN_COUNT; i++) begin
            inv_nxt[i] = pad_config_nxt[i].pad_invert_enable;
            pad_ctrl_nxt.pull_high[i] = pad_config_nxt[i].pad_pull_high_enable
                                        && !drive_select_nxt[i];
            pad_ctrl_nxt.input_buffer_on[i] = buffer_on(pad_config_nxt[i].sense_select);
        end
        // Level only matters where the driver is on; the pad ignores it otherwise.
        pad_ctrl_nxt.drive_value = drive_level_nxt ^ inv_nxt;
        pad_ctrl_nxt.drive_off_n = ~drive_select_nxt;
        pad_ctrl_nxt.slew_limit_enable = slew_control_nxt[SLEW_LIMIT_BIT];
    end

    // Read data is captured in the setup cycle so it is stable through the access phase.
    always_comb begin
        prdata_nxt = prdata_r;
        if (rd_setup) begin
            prdata_nxt = 32'h0000_0000;
            unique case (sel)
                SEL_DRIVE_SELECT:   prdata_nxt[7:0] = drive_select_r;
                SEL_DRIVE_LEVEL:    prdata_nxt[7:0] = drive_level_r;
                SEL_SAMPLED_LEVELS: prdata_nxt[7:0] = sampled_r;
                SEL_EVENT_FLAGS:    prdata_nxt[7:0] = event_flags_r;
                SEL_SLEW_CONTROL:   prdata_nxt[7:0] = slew_control_r;
                SEL_PAD_CONFIG:     prdata_nxt[7:0] = pad_config_r[pin_idx];
                default:            prdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_select_r <= RST_DRIVE_SELECT;
            drive_level_r  <= RST_DRIVE_LEVEL;
            sampled_r      <= RST_SAMPLED_LEVELS;
            event_flags_r  <= RST_EVENT_FLAGS;
            slew_control_r <= RST_SLEW_CONTROL;
            for (int i = 0; i < PIN_COUNT; i++) begin
                pad_config_r[i] <= RST_PAD_CONFIG;
            end
            prdata_r       <= 32'h0000_0000;
            pad_ctrl_r     <= '{drive_value: 8'h00, drive_off_n: 8'hff, pull_high: 8'h00,
                                input_buffer_on: 8'hff, slew_limit_enable: 1'b0};
            irq_r          <= 1'b0;
        end else begin
            drive_select_r <= drive_select_nxt;
            drive_level_r  <= drive_level_nxt;
            sampled_r      <= sampled_nxt;
            event_flags_r  <= event_flags_nxt;
            slew_control_r <= slew_control_nxt;
            for (int i = 0; i < PIN_COUNT; i++) begin
                pad_config_r[i] <= pad_config_nxt[i];
            end
            prdata_r       <= prdata_nxt;
            pad_ctrl_r     <= pad_ctrl_nxt;
            irq_r          <= irq_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign prdata   = prdata_r;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && (sel == SEL_NONE);
    assign pad_ctrl = pad_ctrl_r;
    assign port_irq = irq_r;

endmodule // gpfp_port

// *** gpfp_pkg.sv ***
// Package for the eight-pin port: register indices, field layout, reset values and types.
// Assumes a 32-bit APB bus whose byte address is four times the register index.
//
// What this block does
// - Port slew bit set limits slew on all eight pins; clear disables it on all.
// - Pin invert bit inverts both the driven value and the sampled value.
// - Pull-up is on only when enabled and the pin is input-only.
// - Sense code 0x0 keeps the input buffer on and makes no event.
// - Sense code 0x1 flags both rising and falling sampled transitions.
// - Sense code 0x2 flags rising sampled transitions only.
// - Sense code 0x3 flags falling sampled transitions only.
// - Sense code 0x4 disables both the event and the input buffer.
// - Sense code 0x5 flags the pin while its sampled value is low.
// - With the input buffer off the sampled bit holds its old value.
// - Fast view accesses act exactly like the matching regular view accesses.
// - Fast view event flags sit at index 0x03 after drive, level, sampled.
// - Direction bit 1 enables the driver; 0 makes the pin input-only.
// - Direction does not touch the input buffer; only sense select does.
// - Output level reaches the pin only while the driver is enabled.
// - With the driver on and invert clear, level 0 drives low and level 1 drives high.
// - Writing 1s to the sampled-levels register toggles those output-level bits.
// - With invert clear and the buffer on, reading sampled levels gives 1 for a high pin and 0 for low.
// - An event flag sets when the pin matches its sense selection.
// - Writing 1 clears an event flag; writing 0 leaves it.
package gpfp_pkg;

    // ==========================================================
    // Geometry
    localparam int unsigned PIN_COUNT = 8;
    localparam int unsigned ADDR_W    = 12;

    // ==========================================================
    // Register indices (byte address is index times four)
    localparam logic [9:0] IDX_FAST_DRIVE_SELECT    = 10'h000;
    localparam logic [9:0] IDX_FAST_DRIVE_LEVEL     = 10'h001;
    localparam logic [9:0] IDX_FAST_SAMPLED_LEVELS  = 10'h002;
    localparam logic [9:0] IDX_FAST_EVENT_FLAGS     = 10'h003;
    localparam logic [9:0] IDX_PORT_SLEW_CONTROL    = 10'h00a;
    localparam logic [9:0] IDX_PAD_CONFIG_BASE      = 10'h010;
    localparam logic [9:0] IDX_REG_DRIVE_SELECT     = 10'h020;
    localparam logic [9:0] IDX_REG_DRIVE_LEVEL      = 10'h024;
    localparam logic [9:0] IDX_REG_SAMPLED_LEVELS   = 10'h028;
    localparam logic [9:0] IDX_REG_EVENT_FLAGS      = 10'h029;

    // ==========================================================
    // Field positions
    localparam int unsigned SLEW_LIMIT_BIT = 0;
    localparam logic [7:0]  PAD_CONFIG_RW_MASK = 8'h8f;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_DRIVE_SELECT   = 8'h00;
    localparam logic [7:0] RST_DRIVE_LEVEL    = 8'h00;
    localparam logic [7:0] RST_SAMPLED_LEVELS = 8'h00;
    localparam logic [7:0] RST_EVENT_FLAGS    = 8'h00;
    localparam logic [7:0] RST_SLEW_CONTROL   = 8'h00;
    localparam logic [7:0] RST_PAD_CONFIG     = 8'h00;

    // ==========================================================
    // Sense select codes
    localparam logic [2:0] SENSE_OFF_BUFFER_ON   = 3'h0;
    localparam logic [2:0] SENSE_ANY_TRANSITION  = 3'h1;
    localparam logic [2:0] SENSE_RISING          = 3'h2;
    localparam logic [2:0] SENSE_FALLING         = 3'h3;
    localparam logic [2:0] SENSE_BUFFER_OFF      = 3'h4;
    localparam logic [2:0] SENSE_LOW_LEVEL       = 3'h5;

    // ==========================================================
    // Types
    typedef struct packed {
        logic       pad_invert_enable;
        logic [2:0] reserved;
        logic       pad_pull_high_enable;
        logic [2:0] sense_select;
    } gpfp_pad_config_s;

    typedef struct packed {
        logic [7:0] drive_value;
        logic [7:0] drive_off_n;
        logic [7:0] pull_high;
        logic [7:0] input_buffer_on;
        logic       slew_limit_enable;
    } gpfp_pad_ctrl_s;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_DRIVE_SELECT,
        SEL_DRIVE_LEVEL,
        SEL_SAMPLED_LEVELS,
        SEL_EVENT_FLAGS,
        SEL_SLEW_CONTROL,
        SEL_PAD_CONFIG
    } gpfp_reg_sel_e;

endpackage

// *** gpfp_port_sva.sv ***
// Checker for the eight-pin port, watching only its top-level ports.
// Assumes one pclk domain and an active-low presetn.
`timescale 1ns/10ps
module gpfp_port_sva
    import gpfp_pkg::*;
(
    // Clock and reset
    input wire logic           pclk,
    input wire logic           presetn,
    // APB
    input wire logic           psel,
    input wire logic           penable,
    input wire logic           pwrite,
    input wire logic [11:0]    paddr,
    input wire logic [31:0]    pwdata,
    // Pads and request
    input wire gpfp_pad_ctrl_s pad_ctrl,
    input wire logic           port_irq
);
    // ==========
    // Helpers
    wire logic wr = psel && penable && pwrite;
    wire logic fl = wr && (paddr == 12'h00c || paddr == 12'h0a4);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========
    // Properties
    a_dir_write: assert property (wr && (paddr == 12'h000 || paddr == 12'h080)
        |=> pad_ctrl.drive_off_n == ~$past(pwdata[7:0])) else $error("Drive enable wrong.");
    a_slew_write: assert property (wr && paddr == 12'h028
        |=> pad_ctrl.slew_limit_enable == $past(pwdata[0])) else $error("Slew bit wrong.");
    a_slew_hold: assert property (!(wr && paddr == 12'h028)
        |=> $stable(pad_ctrl.slew_limit_enable)) else $error("Slew bit moved.");
    a_pull_input: assert property ((pad_ctrl.pull_high & ~pad_ctrl.drive_off_n) == 8'h00)
        else $error("Pull-up on a driven pin.");
    a_buf_sense: assert property (wr && paddr[11:5] == 7'h02 && paddr[1:0] == 2'h0
        |=> pad_ctrl.input_buffer_on[$past(paddr[4:2])] == ($past(pwdata[2:0]) != 3'h4))
        else $error("Input buffer does not follow sense code.");
    a_dir_no_buf: assert property (wr && paddr == 12'h000
        |=> $stable(pad_ctrl.input_buffer_on)) else $error("Direction moved input buffer.");
    a_toggle_level: assert property (wr && (paddr == 12'h008 || paddr == 12'h0a0)
        |=> pad_ctrl.drive_value == ($past(pad_ctrl.drive_value) ^ $past(pwdata[7:0])))
        else $error("Sampled-levels write did not toggle.");
    a_irq_fall: assert property ($fell(port_irq) |-> $past(fl))
        else $error("Request dropped without a flag clear.");
    a_zero_keep: assert property (fl && pwdata[7:0] == 8'h00 |=> !$fell(port_irq))
        else $error("Zero write cleared a flag.");
endmodule // gpfp_port_sva
bind gpfp_port gpfp_port_sva chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pad_ctrl(pad_ctrl), .port_irq(port_irq));

// *** gpfp_pads.sv ***
// Board-side pad model: port drive, external drivers, pull-ups.
// Assumes the bench never drives a pin the port is driving.
`timescale 1ns/10ps
module gpfp_pads
    import gpfp_pkg::*;
(
    // Clock
    input wire logic                 pclk,
    // Port side
    input wire gpfp_pad_ctrl_s       pad_ctrl,
    // Board side
    input wire logic [PIN_COUNT-1:0] ext_val,
    input wire logic [PIN_COUNT-1:0] ext_en,
    output logic     [PIN_COUNT-1:0] pad_level
);
    // A floating pad flips every cycle, so a stale level is never read as real.
    logic [PIN_COUNT-1:0] float_r = 8'h55;
    always @(posedge pclk) float_r <= ~float_r;
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (!pad_ctrl.drive_off_n[i]) pad_level[i] = pad_ctrl.drive_value[i];
            else if (ext_en[i]) pad_level[i] = ext_val[i];
            else if (pad_ctrl.pull_high[i]) pad_level[i] = 1'b1;
            else pad_level[i] = float_r[i];
        end
    end
endmodule // gpfp_pads

// *** gpfp_port_test.sv ***
// Self-checking bench for the eight-pin port over APB with a pad model.
// Assumes zero-wait APB answers are possible but waits on pready anyway.
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module gpfp_port_test import gpfp_pkg::*; ();
    logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, port_irq, er;
    logic [ADDR_W-1:0]    paddr;
    logic [31:0]          pwdata, prdata, rd;
    logic [PIN_COUNT-1:0] pad_in, ext_val, ext_en;
    gpfp_pad_ctrl_s       pad_ctrl;
    int                   err_total, total_checks;
    gpfp_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pad_in(pad_in), .pad_ctrl(pad_ctrl), .port_irq(port_irq));
    gpfp_pads pads_u (.pclk(pclk), .pad_ctrl(pad_ctrl), .ext_val(ext_val), .ext_en(ext_en),
        .pad_level(pad_in));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // ==========
    // Bus and closing tasks
    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            err_total++;
            complete_run();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so a following call never drives psel twice in one time step.
        @(posedge pclk);
    endtask
    // ==========
    // Scenarios
    task automatic t_reset;
        logic [11:0] ra [6] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h028, 12'h040};
        apb(1'b0, 12'h0fc, 8'h00);
        `CHK(er, 1'b1)
        foreach (ra[i]) begin
            apb(1'b0, ra[i], 8'h00);
            `CHK(rd, 32'h0000_0000)
        end
        `CHK(pad_ctrl.drive_off_n, 8'hff)
        $display("test reset done");
    endtask
    task automatic t_drive;
        ext_en <= 8'hf0;
        ext_val <= 8'ha0;
        apb(1'b1, 12'h000, 8'h0f);
        apb(1'b1, 12'h004, 8'h55);
        @(posedge pclk);
        `CHK(pad_ctrl.drive_off_n, 8'hf0)
        `CHK(pad_ctrl.drive_value, 8'h55)
        apb(1'b0, 12'h080, 8'h00);
        `CHK(rd, 32'h0000_000f)
        apb(1'b0, 12'h0a0, 8'h00);
        `CHK(rd, 32'h0000_00a5)
        apb(1'b1, 12'h008, 8'h03);
        apb(1'b0, 12'h004, 8'h00);
        `CHK(rd, 32'h0000_0056)
        $display("test drive done");
    endtask
    task automatic t_config;
        apb(1'b1, 12'h040, 8'hf8);
        apb(1'b0, 12'h040, 8'h00);
        `CHK(rd, 32'h0000_0088)
        `CHK(pad_ctrl.drive_value[0], 1'b1)
        apb(1'b0, 12'h008, 8'h00);
        `CHK(rd, 32'h0000_00a6)
        apb(1'b1, 12'h050, 8'h08);
        @(posedge pclk);
        `CHK(pad_ctrl.pull_high, 8'h10)
        apb(1'b1, 12'h028, 8'h01);
        @(posedge pclk);
        `CHK(pad_ctrl.slew_limit_enable, 1'b1)
        apb(1'b1, 12'h028, 8'h00);
        `CHK(pad_ctrl.slew_limit_enable, 1'b0)
        apb(1'b1, 12'h040, 8'h00);
        $display("test config done");
    endtask
    task automatic t_sense;
        // Software never writes the reserved sense codes 0x6 and 0x7.
        for (int c = 0; c < 6; c++) begin
            apb(1'b1, 12'h05c, 8'(c));
            apb(1'b1, 12'h0a4, 8'hff);
            ext_val <= 8'h00;
            repeat (3) @(posedge pclk);
            apb(1'b1, 12'h00c, 8'h00);
            apb(1'b0, 12'h00c, 8'h00);
            `CHK(rd[7], 1'(c == 1 || c == 3 || c == 5))
            `CHK(port_irq, 1'(c == 1 || c == 3 || c == 5))
            apb(1'b0, 12'h008, 8'h00);
            `CHK(rd[7], 1'(c == 4))
            apb(1'b1, 12'h0a4, 8'h80);
            apb(1'b0, 12'h0a4, 8'h00);
            `CHK(rd[7], 1'(c == 5))
            ext_val <= 8'h80;
            repeat (3) @(posedge pclk);
            apb(1'b0, 12'h00c, 8'h00);
            `CHK(rd[7], 1'(c == 1 || c == 2 || c == 5))
        end
        $display("test sense done");
    endtask
    initial begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        ext_en = 8'hff;
        ext_val = 8'h00;
        err_total = 0;
        total_checks = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_drive();
        t_config();
        t_sense();
        complete_run();
    end
endmodule // gpfp_port_test
